// >>> logic/crbgt_gate.sv
// Locality access gate for a command-response-buffer register set, reached over AXI4-Lite.
// Assumes the master keeps one write and one read in flight; locality comes from address bits 14:12.
//
// What this block does
// - Active locality changing during a running command aborts that command.
// - Non-owner or unowned access: buffer control and data read FFh, writes ignored.
// - Owner writes to the data buffer are taken as command or data bytes unless a command is running.
// - Owner reads of the data buffer return the finished command's response bytes.
// - Digest begin accepted from owner or when unowned; unowned case makes locality 4 owner.
// - Digest feed from owner consumes the command buffer; otherwise ignored.
// - When attached over the legacy pin link, that link's requirements govern the device.
// - Clock-stop support on the legacy link is optional.
// - Power-down input tied high must disable the power-down protocol entirely.
// - The buffer register interface is not offered when attached over the legacy link.
`timescale 1ns/1ps
module crbgt_gate
	import crbgt_pkg::*;
#(
	parameter int EXEC_CYC = EXEC_CYCLES
) (
	input  wire logic              clk_sys,
	input  wire logic              resetn,
	input  wire logic              legacy_link_strap,
	input  wire logic              link_powerdown_n,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic [3:0]             current_owner_level,
	output logic                   cmd_busy,
	output logic                   cmd_abort
);
	// Decodes the offset within a locality page; shared by the read and write paths.
	function automatic crbgt_kind_e reg_kind(input logic [ADDR_W-1:0] a);
		logic [11:0] o;
		o = a[11:0];
		if (a[ADDR_W-1:LOC_LSB+LOC_W] != '0 || a[LOC_LSB+LOC_W-1:LOC_LSB] > LOC_DIGEST) begin
			reg_kind = K_NONE;
		end else if (o == OFF_LOC_STATE) begin
			reg_kind = K_STATE;
		end else if (o == OFF_LOC_CTRL) begin
			reg_kind = K_CTRL;
		end else if (o == OFF_BUF_CTRL) begin
			reg_kind = K_BCTRL;
		end else if (o == OFF_CSUM) begin
			reg_kind = K_CSUM;
		end else if (o == OFF_CSUM_EN) begin
			reg_kind = K_CSUM_EN;
		end else if (o == OFF_DIGEST) begin
			reg_kind = K_DIGEST;
		end else if (o >= OFF_BUF_BASE && o <= OFF_BUF_LAST && o[1:0] == 2'h0) begin
			reg_kind = K_BUF;
		end else begin
			reg_kind = K_NONE;
		end
	endfunction : reg_kind

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
		for (int i = 0; i < 4; i++) begin
			merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction : merge

	logic [31:0]       buf_mem [BUF_WORDS];
	logic              legacy_reg;
	crbgt_owner_s      owner_reg;
	crbgt_owner_s      owner_next;
	crbgt_cmd_e        cmd_reg;
	logic [7:0]        exec_cnt_reg;
	logic              aborted_reg;
	logic              csum_en_reg;
	logic [31:0]       csum_reg;
	logic [31:0]       digest_acc_reg;
	logic [31:0]       digest_reg;
	logic              digest_open_reg;
	logic              aw_hold_reg;
	logic              w_hold_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [31:0]       wdata_reg;
	logic [3:0]        wstrb_reg;
	logic              wr_fire;
	logic              powered_down;
	logic              gate_closed;
	logic [2:0]        wr_loc;
	logic [2:0]        rd_loc;
	logic              wr_owner;
	logic              rd_owner;
	crbgt_kind_e       wr_kind;
	crbgt_kind_e       rd_kind;
	logic [31:0]       rd_word;
	logic [31:0]       buf_fold;
	logic              owner_changed;

	// The strap is sampled while reset is held so a later glitch cannot reopen the buffer interface.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			legacy_reg <= legacy_link_strap;
		end
	end

	// Low-power state only exists on the legacy link; a pin tied high never enters it.
	assign powered_down = legacy_reg && !link_powerdown_n;
	// Legacy attachment hides every buffer register; clock-stop is not used, so the link clock must run.
	assign gate_closed  = legacy_reg || powered_down;

	assign wr_fire  = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
	assign wr_loc   = awaddr_reg[LOC_LSB +: LOC_W];
	assign rd_loc   = s_axi_araddr[LOC_LSB +: LOC_W];
	assign wr_kind  = reg_kind(awaddr_reg);
	assign rd_kind  = reg_kind(s_axi_araddr);
	assign wr_owner = owner_reg.valid && owner_reg.level == wr_loc;
	assign rd_owner = owner_reg.valid && owner_reg.level == rd_loc;

	always_comb begin
		buf_fold = '0;
		for (int i = 0; i < BUF_WORDS; i++) begin
			buf_fold = {buf_fold[30:0], buf_fold[31]} ^ buf_mem[i];
		end
	end

	// Ownership: request, relinquish and the digest sequence all move the active locality.
	always_comb begin
		owner_next = owner_reg;
		if (wr_fire && !gate_closed && wr_kind == K_CTRL) begin
			if (wstrb_reg[0] && wdata_reg[LC_REQUEST] && !owner_reg.valid) begin
				owner_next = '{valid: 1'b1, level: wr_loc};
			end else if (wstrb_reg[0] && wdata_reg[LC_RELINQUISH] && wr_owner) begin
				owner_next = OWNER_NONE;
			end else if (wr_loc == LOC_DIGEST && wstrb_reg[0] && wdata_reg[LC_BEGIN] && !owner_reg.valid) begin
				owner_next = '{valid: 1'b1, level: LOC_DIGEST};
			end else if (wr_loc == LOC_DIGEST && wstrb_reg[0] && wdata_reg[LC_FINISH] && wr_owner && digest_open_reg) begin
				owner_next = OWNER_NONE;
			end
		end
	end

	assign owner_changed = owner_next != owner_reg;

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			owner_reg <= OWNER_NONE;
		end else if (powered_down) begin
			owner_reg <= OWNER_NONE;
		end else begin
			owner_reg <= owner_next;
		end
	end

	// Command engine: start runs for a fixed time, then the buffer holds the response.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			cmd_reg      <= CRBGT_IDLE;
			exec_cnt_reg <= 8'h00;
			aborted_reg  <= 1'b0;
			cmd_abort    <= 1'b0;
		end else begin
			cmd_abort <= 1'b0;
			case (cmd_reg)
				CRBGT_IDLE, CRBGT_DONE: begin
					if (wr_fire && !gate_closed && wr_kind == K_BCTRL && wr_owner && wstrb_reg[0] &&
					    wdata_reg[BC_START]) begin
						cmd_reg      <= CRBGT_EXEC;
						exec_cnt_reg <= 8'(EXEC_CYC - 1);
						aborted_reg  <= 1'b0;
					end
				end
				CRBGT_EXEC: begin
					if (owner_changed || powered_down ||
					    (wr_fire && wr_kind == K_BCTRL && wr_owner && wstrb_reg[0] && wdata_reg[BC_CANCEL])) begin
						cmd_reg     <= CRBGT_IDLE;
						aborted_reg <= 1'b1;
						cmd_abort   <= 1'b1;
					end else if (exec_cnt_reg == 8'h00) begin
						cmd_reg <= CRBGT_DONE;
					end else begin
						exec_cnt_reg <= exec_cnt_reg - 8'h01;
					end
				end
				default: cmd_reg <= CRBGT_IDLE;
			endcase
		end
	end

	// Buffer writes land only for the owner; the engine has the buffer to itself while running.
	always_ff @(posedge clk_sys) begin
		if (wr_fire && !gate_closed && wr_kind == K_BUF && wr_owner && cmd_reg != CRBGT_EXEC) begin
			buf_mem[awaddr_reg[6:2]] <= merge(buf_mem[awaddr_reg[6:2]], wdata_reg, wstrb_reg);
		end
	end

	// Digest sequence and checksum of the buffer contents.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			digest_open_reg <= 1'b0;
			digest_acc_reg  <= DIGEST_RESET;
			digest_reg      <= DIGEST_RESET;
			csum_en_reg     <= 1'b0;
			csum_reg        <= '0;
		end else begin
			csum_reg <= csum_en_reg ? buf_fold : '0;
			if (wr_fire && !gate_closed && wr_kind == K_CSUM_EN && wstrb_reg[0]) begin
				csum_en_reg <= wdata_reg[0];
			end
			if (wr_fire && !gate_closed && wr_kind == K_CTRL && wr_loc == LOC_DIGEST && wstrb_reg[0]) begin
				if (wdata_reg[LC_BEGIN] && (wr_owner || !owner_reg.valid)) begin
					digest_open_reg <= 1'b1;
					digest_acc_reg  <= DIGEST_RESET;
				end else if (wdata_reg[LC_FEED] && wr_owner && digest_open_reg) begin
					digest_acc_reg <= {digest_acc_reg[30:0], digest_acc_reg[31]} ^ buf_fold;
				end else if (wdata_reg[LC_FINISH] && wr_owner && digest_open_reg) begin
					digest_reg      <= {digest_reg[15:0], digest_reg[31:16]} ^ digest_acc_reg;
					digest_open_reg <= 1'b0;
				end
			end
		end
	end

	// Read data; refused reads of guarded registers answer all ones.
	always_comb begin
		rd_word = '0;
		case (rd_kind)
			K_STATE:   rd_word = {27'h0, cmd_reg == CRBGT_EXEC, owner_reg.valid, owner_reg.level};
			K_CTRL:    rd_word = '0;
			K_BCTRL:   rd_word = rd_owner ? {28'h0, aborted_reg, cmd_reg == CRBGT_DONE, 1'b0,
			                     cmd_reg == CRBGT_EXEC} : READ_REFUSED;
			K_CSUM:    rd_word = rd_owner ? csum_reg : READ_REFUSED;
			K_CSUM_EN: rd_word = {31'h0, csum_en_reg};
			K_DIGEST:  rd_word = digest_reg;
			K_BUF:     rd_word = (rd_owner && cmd_reg != CRBGT_EXEC) ? buf_mem[s_axi_araddr[6:2]] :
			                     READ_REFUSED;
			default:   rd_word = '0;
		endcase
		if (gate_closed) begin
			rd_word = READ_REFUSED;
		end
	end

	// Write address and data are taken independently and held until the response is accepted.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			aw_hold_reg   <= 1'b0;
			w_hold_reg    <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			awaddr_reg    <= '0;
			wdata_reg     <= '0;
			wstrb_reg     <= '0;
		end else begin
			s_axi_awready <= !aw_hold_reg && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !w_hold_reg && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_reg <= 1'b1;
				awaddr_reg  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_kind == K_NONE) ? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				aw_hold_reg   <= 1'b0;
				w_hold_reg    <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Reads answer one cycle after the address is taken.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_word;
				s_axi_rresp   <= (rd_kind == K_NONE) ? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end else if (!s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
			end
		end
	end

	// Status pins mirror internal state one cycle late so they come straight from flops.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			current_owner_level <= 4'h0;
			cmd_busy            <= 1'b0;
		end else begin
			current_owner_level <= {owner_reg.valid, owner_reg.level};
			cmd_busy            <= cmd_reg == CRBGT_EXEC;
		end
	end
endmodule : crbgt_gate

// >>> logic/crbgt_pkg.sv
// Constants, types and the register map of the locality access gate.
// Assumes a single 50 MHz system clock and an AXI4-Lite master with 32-bit data.
package crbgt_pkg;
	localparam int          CLK_PERIOD_NS     = 20;
	localparam int          EXEC_TIME_NS      = 2000;
	localparam int          EXEC_CYCLES       = (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          ADDR_W            = 16;
	localparam int          LOC_LSB           = 12;
	localparam int          LOC_W             = 3;
	localparam int          BUF_WORDS         = 32;
	localparam logic [2:0]  LOC_DIGEST        = 3'h4;
	localparam logic [11:0] OFF_LOC_STATE     = 12'h000;
	localparam logic [11:0] OFF_LOC_CTRL      = 12'h008;
	localparam logic [11:0] OFF_BUF_CTRL      = 12'h040;
	localparam logic [11:0] OFF_CSUM          = 12'h044;
	localparam logic [11:0] OFF_CSUM_EN       = 12'h048;
	localparam logic [11:0] OFF_DIGEST        = 12'h04c;
	localparam logic [11:0] OFF_BUF_BASE      = 12'h080;
	localparam logic [11:0] OFF_BUF_LAST      = 12'h0fc;
	localparam int          LC_REQUEST        = 0;
	localparam int          LC_RELINQUISH     = 1;
	localparam int          LC_BEGIN          = 2;
	localparam int          LC_FEED           = 3;
	localparam int          LC_FINISH         = 4;
	localparam int          BC_START          = 0;
	localparam int          BC_CANCEL         = 1;
	localparam int          BC_DONE           = 2;
	localparam int          BC_ABORTED        = 3;
	localparam logic [31:0] READ_REFUSED      = 32'hffffffff;
	localparam logic [31:0] DIGEST_RESET      = 32'h00000000;
	localparam logic [1:0]  RESP_OKAY         = 2'h0;
	localparam logic [1:0]  RESP_SLVERR       = 2'h2;

	typedef enum {CRBGT_IDLE, CRBGT_EXEC, CRBGT_DONE} crbgt_cmd_e;
	typedef enum {K_NONE, K_STATE, K_CTRL, K_BCTRL, K_CSUM, K_CSUM_EN, K_DIGEST, K_BUF} crbgt_kind_e;

	typedef struct packed {
		logic       valid;
		logic [2:0] level;
	} crbgt_owner_s;

	localparam crbgt_owner_s OWNER_NONE = '{valid: 1'b0, level: 3'h0};
endpackage : crbgt_pkg

// >>> verif/crbgt_gate_props.sv
// Port-level checks of the locality access gate.
// Assumes reads and writes do not overlap, so ownership is steady while a read is taken.
`timescale 1ns/1ps
module crbgt_gate_props
	import crbgt_pkg::*;
(
	input wire logic              clk_sys,
	input wire logic              resetn,
	input wire logic              legacy_link_strap,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic [31:0]       s_axi_wdata,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic              s_axi_bvalid,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic              s_axi_rvalid,
	input wire logic [3:0]        current_owner_level,
	input wire logic              cmd_busy,
	input wire logic              cmd_abort
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);
	logic [ADDR_W-1:0] aw_reg;
	logic [31:0]       wd_reg;
	logic              mapped;
	logic              hit;
	assign mapped = !s_axi_araddr[15] && s_axi_araddr[14:12] <= 3'h4;
	assign hit    = current_owner_level == {1'b1, s_axi_araddr[14:12]};
	always_ff @(posedge clk_sys) begin
		if (s_axi_awvalid && s_axi_awready) aw_reg <= s_axi_awaddr;
	end
	always_ff @(posedge clk_sys) begin
		if (s_axi_wvalid && s_axi_wready) wd_reg <= s_axi_wdata;
	end
	sequence ar_take;
		s_axi_arvalid && s_axi_arready && mapped;
	endsequence
	// Ownership is sampled at the response, before the write's effect reaches the owner port.
	sequence ctl4_done;
		$rose(s_axi_bvalid) && aw_reg[15:12] == 4'h4 && aw_reg[11:0] == OFF_LOC_CTRL && !legacy_link_strap;
	endsequence
	a_abort_on_change: assert property ($changed(current_owner_level) && $past(cmd_busy) |->
		$past(cmd_abort)) else $error("owner changed in a command without abort");
	a_abort_needs_cmd: assert property (cmd_abort |-> $past(cmd_busy) || $past(cmd_busy, 2))
		else $error("abort with no command running");
	a_refused_read: assert property (ar_take ##0 (!hit && (s_axi_araddr[11:0] == OFF_BUF_CTRL ||
		(s_axi_araddr[11:0] >= OFF_BUF_BASE && s_axi_araddr[11:0] <= OFF_BUF_LAST))) |=>
		s_axi_rvalid && s_axi_rdata == READ_REFUSED) else $error("refused read did not return all ones");
	a_control_zero: assert property (ar_take ##0 (!legacy_link_strap && s_axi_araddr[11:0] == OFF_LOC_CTRL)
		|=> s_axi_rdata == 32'h0) else $error("control read not zero");
	a_legacy_refuses: assert property (ar_take ##0 (legacy_link_strap && s_axi_araddr[11:0] == OFF_LOC_STATE)
		|=> s_axi_rdata == READ_REFUSED) else $error("register set offered on legacy link");
	a_begin_sets_four: assert property (ctl4_done ##0 (wd_reg[2] && !wd_reg[1] && !current_owner_level[3])
		|-> ##[0:2] current_owner_level == 4'hc) else $error("digest begin did not make level 4 owner");
	a_begin_ignored: assert property (ctl4_done ##0 (wd_reg[4:0] == 5'h4 && current_owner_level[3] &&
		current_owner_level[2:0] != 3'h4) |=> $stable(current_owner_level) [*2]) else $error("begin took owner");
	a_finish_frees: assert property (ctl4_done ##0 (wd_reg[4:0] == 5'h10 && current_owner_level == 4'hc)
		|-> ##[0:2] !current_owner_level[3]) else $error("digest finish did not release owner");
endmodule : crbgt_gate_props

bind crbgt_gate crbgt_gate_props u_props (.clk_sys, .resetn, .legacy_link_strap, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .current_owner_level, .cmd_busy, .cmd_abort);

// >>> verif/crbgt_host.sv
// Host master model: one AXI4-Lite write or read at a time.
// Assumes one caller; a wait that runs dry raises hang. Released lines show inverted values.
`timescale 1ns/1ps
module crbgt_host (
	input  wire logic        clk_sys,
	output logic [15:0]      s_axi_awaddr,
	output logic             s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic [31:0]      s_axi_wdata,
	output logic             s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic        s_axi_bvalid,
	output logic             s_axi_bready,
	output logic [15:0]      s_axi_araddr,
	output logic             s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic        s_axi_rvalid,
	output logic             s_axi_rready,
	output logic             hang
);
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready, hang} = '0;
	end
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		for (k = 0; k < 200; k++) begin
			@(posedge clk_sys);
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~a;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~d;
			end
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		hang <= hang | (k == 200);
	endtask : wr
	task automatic rd(input logic [15:0] a);
		int k;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		for (k = 0; k < 200; k++) begin
			@(posedge clk_sys);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arvalid <= 1'b0;
				s_axi_araddr <= ~a;
			end
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'b0;
		hang <= hang | (k == 200);
	endtask : rd
endmodule : crbgt_host

// >>> verif/crb_locality_access_gate_tb.sv
// Self-checking bench of the locality access gate driven by the host model.
// Assumes read answers come back in issue order; a queue holds the expected ones.
`timescale 1ns/1ps
module crb_locality_access_gate_tb;
	import crbgt_pkg::*;
	typedef struct packed {
		logic [31:0] data;
		logic [31:0] mask;
		logic [1:0]  resp;
	} crbgt_note_s;
	logic        clk_sys = 1'b0, resetn = 1'b0, legacy_link_strap = 1'b0, link_powerdown_n = 1'b1;
	logic [15:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d, seed = 32'h8ac3, fold = '0;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, hang;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, cmd_busy, cmd_abort;
	logic [3:0]  current_owner_level;
	logic [11:0] o;
	crbgt_note_s notes[$], note;
	int          err_total = 0, comparisons = 0, aborts = 0, n;
	// A short command keeps the run brief yet leaves room to change owner mid-command.
	crbgt_gate #(.EXEC_CYC(8)) uut (.clk_sys, .resetn, .legacy_link_strap, .link_powerdown_n, .s_axi_awaddr,
		.s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.current_owner_level, .cmd_busy, .cmd_abort);
	crbgt_host host (.clk_sys, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
		.s_axi_rready, .hang);
	always #10 clk_sys = ~clk_sys;
	function automatic logic [15:0] adr(input logic [2:0] l, input logic [11:0] off);
		return {1'b0, l, off};
	endfunction : adr
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic [31:0] m = '1, input logic [1:0] r = 2'h0);
		notes.push_back('{e, m, r});
		host.rd(a);
	endtask : rd
	task automatic own(input logic [3:0] e);
		@(negedge clk_sys);
		chk("owner", {28'h0, e}, {28'h0, current_owner_level});
	endtask : own
	task automatic wait_idle;
		@(negedge clk_sys);
		for (n = 0; n < 100 && cmd_busy !== 1'b0; n++) @(negedge clk_sys);
		chk("busy wait", 32'h0, {31'h0, n == 100});
		if (n == 100) end_of_test();
	endtask : wait_idle
	always @(posedge clk_sys) begin
		if (cmd_abort === 1'b1) aborts++;
		if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
			chk("write response", {30'h0, RESP_OKAY}, {30'h0, s_axi_bresp});
		end
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
			note = notes.pop_front();
			chk("read data", note.data & note.mask, s_axi_rdata & note.mask);
			chk("read response", {30'h0, note.resp}, {30'h0, s_axi_rresp});
		end
	end
	always @(posedge hang) begin
		err_total++;
		end_of_test();
	end
	initial begin
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (2) @(posedge clk_sys);
		own(4'h0);
		rd(adr(0, OFF_BUF_CTRL), READ_REFUSED);
		host.wr(adr(0, OFF_LOC_CTRL), 32'h1);
		own(4'h8);
		host.wr(adr(4, OFF_LOC_CTRL), 32'h4);
		own(4'h8);
		seed = lfsr(seed);
		d = seed;
		o = OFF_BUF_BASE + {5'h0, seed[6:2], 2'h0};
		host.wr(adr(0, o), d);
		rd(adr(0, o), d);
		for (int l = 1; l < 5; l++) rd(adr(l[2:0], o), READ_REFUSED);
		host.wr(adr(1, o), ~d);
		rd(adr(0, o), d);
		rd(adr(0, OFF_LOC_CTRL), 32'h0);
		host.wr(adr(0, OFF_BUF_CTRL), 32'h1);
		wait_idle();
		rd(adr(0, OFF_BUF_CTRL), 32'h4, 32'h5);
		host.wr(adr(0, OFF_BUF_CTRL), 32'h1);
		host.wr(adr(0, OFF_LOC_CTRL), 32'h2);
		own(4'h0);
		wait_idle();
		chk("aborts", 32'h1, 32'(aborts));
		host.wr(adr(4, OFF_LOC_CTRL), 32'h4);
		own(4'hc);
		host.wr(adr(0, OFF_LOC_CTRL), 32'h1);
		own(4'hc);
		for (int i = 0; i < BUF_WORDS; i++) begin
			seed = lfsr(seed);
			fold = {fold[30:0], fold[31]} ^ seed;
			host.wr(adr(4, OFF_BUF_BASE + {5'h0, i[4:0], 2'h0}), seed);
		end
		host.wr(adr(4, OFF_LOC_CTRL), 32'h8);
		own(4'hc);
		rd(adr(4, OFF_LOC_CTRL), 32'h0);
		host.wr(adr(4, OFF_LOC_CTRL), 32'h10);
		own(4'h0);
		rd(adr(4, OFF_DIGEST), fold);
		rd(16'h8000, 32'h0, '1, RESP_SLVERR);
		@(posedge clk_sys);
		resetn <= 1'b0;
		legacy_link_strap <= 1'b1;
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (2) @(posedge clk_sys);
		host.wr(adr(0, OFF_LOC_CTRL), 32'h1);
		own(4'h0);
		rd(adr(0, OFF_LOC_STATE), READ_REFUSED);
		rd(adr(0, o), READ_REFUSED);
		@(negedge clk_sys);
		chk("aborts", 32'h1, 32'(aborts));
		end_of_test();
	end
endmodule : crb_locality_access_gate_tb
